// File: rtl/gpcde_top.sv
// parallel i/o for ports c, d and e with axi4-lite register access
// assumes pins are asynchronous to REF_CLK; peripherals run on REF_CLK
// Contract
// - port c data read: latch or pin
// - port d data read: latch or pin
// - data writes with lane 0 on update the latch, whatever the direction
// - reset leaves port c latches alone
// - port c direction drives; reset clears
// - port d direction drives; reset clears
// - pullup only while pin is input
// - port c pullup enable per input pin
// - port d pullup enable per pin
// - can enable owns port c bits 1,0
// - timer select owns port d bits 7..4
// - spi enable owns port d bits 3..1
// - port d bit 0 spi slave only
// - spi pins: direction only steers reads
// - port e six latches, kept over reset
// - serial enable owns port e bits 1,0
// - serial pins: direction only steers reads
// - port e data read: latch or pin
// - port e direction drives; reset clears
//
// Our own choice: the AXI4-Lite register port.
module gpcde_top (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [gpcde_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [gpcde_pkg::DATA_W-1:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [gpcde_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [gpcde_pkg::DATA_W-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [gpcde_pkg::C_W-1:0] PORT_C_IN,
    output gpcde_pkg::gpcde_drv_c_t PORT_C_DRV,
    input wire logic [gpcde_pkg::D_W-1:0] PORT_D_IN,
    output gpcde_pkg::gpcde_drv_d_t PORT_D_DRV,
    input wire logic [gpcde_pkg::E_W-1:0] PORT_E_IN,
    output gpcde_pkg::gpcde_drv_e_t PORT_E_DRV,
    input wire logic [gpcde_pkg::C_W-1:0] PERIPH_C_OUT,
    input wire logic [gpcde_pkg::C_W-1:0] PERIPH_C_OE,
    input wire logic [gpcde_pkg::D_W-1:0] PERIPH_D_OUT,
    input wire logic [gpcde_pkg::D_W-1:0] PERIPH_D_OE,
    input wire logic [gpcde_pkg::E_W-1:0] PERIPH_E_OUT,
    input wire logic [gpcde_pkg::E_W-1:0] PERIPH_E_OE,
    output logic [gpcde_pkg::C_W-1:0] PORT_C_LEVEL,
    output logic [gpcde_pkg::D_W-1:0] PORT_D_LEVEL,
    output logic [gpcde_pkg::E_W-1:0] PORT_E_LEVEL,
    output logic [gpcde_pkg::MUX_W-1:0] PIN_MUX_CTRL,
    output logic [gpcde_pkg::TIM_CH*gpcde_pkg::ELS_W-1:0] TIMER_ELS
);
    localparam int CW = gpcde_pkg::C_W;
    localparam int DW = gpcde_pkg::D_W;
    localparam int EW = gpcde_pkg::E_W;
    localparam int MW = gpcde_pkg::MUX_W;
    localparam int SW = gpcde_pkg::TIM_CH * gpcde_pkg::ELS_W;
    localparam int IW = gpcde_pkg::IDX_W;

    // two-stage pin synchronisers; only stage two is read by logic
    logic [CW-1:0] c_s1_r, c_s2_r;
    logic [DW-1:0] d_s1_r, d_s2_r;
    logic [EW-1:0] e_s1_r, e_s2_r;

    // data latches: deliberately without reset
    logic [CW-1:0] c_lat_r, c_lat_nxt;
    logic [DW-1:0] d_lat_r, d_lat_nxt;
    logic [EW-1:0] e_lat_r, e_lat_nxt;

    // control registers
    logic [CW-1:0] c_dir_r, c_dir_nxt; // 1 = output
    logic [DW-1:0] d_dir_r, d_dir_nxt;
    logic [EW-1:0] e_dir_r, e_dir_nxt;
    logic [CW-1:0] c_pue_r, c_pue_nxt; // pullup enables
    logic [DW-1:0] d_pue_r, d_pue_nxt;
    logic [MW-1:0] mux_r, mux_nxt; // peripheral pin enables
    logic [SW-1:0] els_r, els_nxt; // timer edge/level selects

    // pin drive registers
    gpcde_pkg::gpcde_drv_c_t c_drv_r, c_drv_nxt;
    gpcde_pkg::gpcde_drv_d_t d_drv_r, d_drv_nxt;
    gpcde_pkg::gpcde_drv_e_t e_drv_r, e_drv_nxt;

    // pins currently owned by a peripheral
    logic [CW-1:0] c_own;
    logic [DW-1:0] d_own;
    logic [EW-1:0] e_own;

    // write channel state
    logic aw_hold_r, aw_hold_nxt;
    logic w_hold_r, w_hold_nxt;
    logic [IW-1:0] aw_idx_r, aw_idx_nxt;
    logic [7:0] w_byte_r, w_byte_nxt; // registers live in lane 0 only
    logic w_lane_r, w_lane_nxt;
    logic awready_r, awready_nxt;
    logic wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;

    // read channel state
    logic arready_r, arready_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [gpcde_pkg::DATA_W-1:0] rdata_r, rdata_nxt;

    // store strobe and hit flag of the completing write
    logic do_wr;
    logic wr_hit;

    // synchronisers run every edge and need no reset
    always_ff @(posedge REF_CLK) begin
        c_s1_r <= PORT_C_IN;
        c_s2_r <= c_s1_r;
        d_s1_r <= PORT_D_IN;
        d_s2_r <= d_s1_r;
        e_s1_r <= PORT_E_IN;
        e_s2_r <= e_s1_r;
    end

    // ownership of shared pins by peripherals
    always_comb begin
        c_own = gpcde_pkg::C_ZERO;
        d_own = gpcde_pkg::D_ZERO;
        e_own = gpcde_pkg::E_ZERO;
        if (mux_r[gpcde_pkg::MUX_CAN]) begin
            c_own = gpcde_pkg::C_CAN_MASK;
        end
        if (mux_r[gpcde_pkg::MUX_SPE]) begin
            d_own = d_own | gpcde_pkg::D_SPI_MASK;
            // slave select only matters to a slave
            if (!mux_r[gpcde_pkg::MUX_MSTR]) begin
                d_own = d_own | gpcde_pkg::D_SS_MASK;
            end
        end
        // any non-zero edge/level select hands the pin to the timer
        for (int k = 0; k < gpcde_pkg::TIM_CH; k++) begin
            if (|els_r[k*gpcde_pkg::ELS_W +: gpcde_pkg::ELS_W]) begin
                d_own[gpcde_pkg::D_TIM_LO+k] = 1'b1;
            end
        end
        if (mux_r[gpcde_pkg::MUX_SCI]) begin
            e_own = gpcde_pkg::E_SCI_MASK;
        end
    end

    // pin drive: peripheral wins on owned pins, direction elsewhere
    always_comb begin
        logic [CW-1:0] c_oe;
        logic [DW-1:0] d_oe;
        logic [EW-1:0] e_oe;
        c_oe = (c_own & PERIPH_C_OE) | (~c_own & c_dir_r);
        d_oe = (d_own & PERIPH_D_OE) | (~d_own & d_dir_r);
        e_oe = (e_own & PERIPH_E_OE) | (~e_own & e_dir_r);
        // output level is zero wherever the driver is off
        c_drv_nxt.out = c_oe & ((c_own & PERIPH_C_OUT) | (~c_own & c_lat_r));
        d_drv_nxt.out = d_oe & ((d_own & PERIPH_D_OUT) | (~d_own & d_lat_r));
        e_drv_nxt.out = e_oe & ((e_own & PERIPH_E_OUT) | (~e_own & e_lat_r));
        c_drv_nxt.oe_n = ~c_oe;
        d_drv_nxt.oe_n = ~d_oe;
        e_drv_nxt.oe_n = ~e_oe;
        // pullups drop out as soon as the pin drives
        c_drv_nxt.pull = c_pue_r & ~c_oe;
        d_drv_nxt.pull = d_pue_r & ~d_oe;
    end

    // pin drive registers: all drivers off during reset
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            c_drv_r <= '{out: gpcde_pkg::C_ZERO, oe_n: ~gpcde_pkg::C_ZERO,
                         pull: gpcde_pkg::C_ZERO};
            d_drv_r <= '{out: gpcde_pkg::D_ZERO, oe_n: ~gpcde_pkg::D_ZERO,
                         pull: gpcde_pkg::D_ZERO};
            e_drv_r <= '{out: gpcde_pkg::E_ZERO, oe_n: ~gpcde_pkg::E_ZERO};
        end else begin
            c_drv_r <= c_drv_nxt;
            d_drv_r <= d_drv_nxt;
            e_drv_r <= e_drv_nxt;
        end
    end

    // next values; the index is decoded every cycle so the answer knows its hit
    always_comb begin
        c_lat_nxt = c_lat_r;
        d_lat_nxt = d_lat_r;
        e_lat_nxt = e_lat_r;
        c_dir_nxt = c_dir_r;
        d_dir_nxt = d_dir_r;
        e_dir_nxt = e_dir_r;
        c_pue_nxt = c_pue_r;
        d_pue_nxt = d_pue_r;
        mux_nxt = mux_r;
        els_nxt = els_r;
        wr_hit = 1'b1;
        // store only on the completing write, and only with lane 0 on
        do_wr = bvalid_nxt && !bvalid_r && w_lane_nxt;
        // latches take writes whatever the direction; bits with no pin are dropped
        if (aw_idx_nxt == gpcde_pkg::IDX_C_DATA) begin
            c_lat_nxt = do_wr ? w_byte_nxt[CW-1:0] : c_lat_r;
        end else if (aw_idx_nxt == gpcde_pkg::IDX_D_DATA) begin
            d_lat_nxt = do_wr ? w_byte_nxt[DW-1:0] : d_lat_r;
        end else if (aw_idx_nxt == gpcde_pkg::IDX_E_DATA) begin
            e_lat_nxt = do_wr ? w_byte_nxt[EW-1:0] : e_lat_r;
        end else if (aw_idx_nxt == gpcde_pkg::IDX_C_DIR) begin
            c_dir_nxt = do_wr ? w_byte_nxt[CW-1:0] : c_dir_r;
        end else if (aw_idx_nxt == gpcde_pkg::IDX_D_DIR) begin
            d_dir_nxt = do_wr ? w_byte_nxt[DW-1:0] : d_dir_r;
        end else if (aw_idx_nxt == gpcde_pkg::IDX_E_DIR) begin
            e_dir_nxt = do_wr ? w_byte_nxt[EW-1:0] : e_dir_r;
        end else if (aw_idx_nxt == gpcde_pkg::IDX_C_PUE) begin
            c_pue_nxt = do_wr ? w_byte_nxt[CW-1:0] : c_pue_r;
        end else if (aw_idx_nxt == gpcde_pkg::IDX_D_PUE) begin
            d_pue_nxt = do_wr ? w_byte_nxt[DW-1:0] : d_pue_r;
        end else if (aw_idx_nxt == gpcde_pkg::IDX_MUX) begin
            mux_nxt = do_wr ? w_byte_nxt[MW-1:0] : mux_r;
        end else if (aw_idx_nxt == gpcde_pkg::IDX_ELS) begin
            els_nxt = do_wr ? w_byte_nxt[SW-1:0] : els_r;
        end else begin
            wr_hit = 1'b0; // unmapped: error answer, nothing stored
        end
    end

    // latches keep their contents across reset
    always_ff @(posedge REF_CLK) begin
        c_lat_r <= c_lat_nxt;
        d_lat_r <= d_lat_nxt;
        e_lat_r <= e_lat_nxt;
    end

    // control registers: every pin an input after reset
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            c_dir_r <= gpcde_pkg::C_ZERO;
            d_dir_r <= gpcde_pkg::D_ZERO;
            e_dir_r <= gpcde_pkg::E_ZERO;
            c_pue_r <= gpcde_pkg::C_ZERO;
            d_pue_r <= gpcde_pkg::D_ZERO;
            mux_r <= gpcde_pkg::MUX_RST;
            els_r <= gpcde_pkg::ELS_RST;
        end else begin
            c_dir_r <= c_dir_nxt;
            d_dir_r <= d_dir_nxt;
            e_dir_r <= e_dir_nxt;
            c_pue_r <= c_pue_nxt;
            d_pue_r <= d_pue_nxt;
            mux_r <= mux_nxt;
            els_r <= els_nxt;
        end
    end

    // write channel: address and data accepted in either order
    always_comb begin
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt = w_hold_r;
        aw_idx_nxt = aw_idx_r;
        w_byte_nxt = w_byte_r;
        w_lane_nxt = w_lane_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        if (S_AXI_AWVALID && awready_r) begin
            aw_hold_nxt = 1'b1;
            aw_idx_nxt = S_AXI_AWADDR[gpcde_pkg::IDX_LO +: IW];
        end
        if (S_AXI_WVALID && wready_r) begin
            w_hold_nxt = 1'b1;
            w_byte_nxt = S_AXI_WDATA[7:0];
            w_lane_nxt = S_AXI_WSTRB[0]; // lane 0 off means no update
        end
        if (bvalid_r && S_AXI_BREADY) begin
            bvalid_nxt = 1'b0;
        end
        if (aw_hold_nxt && w_hold_nxt && !bvalid_r) begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_hit ? gpcde_pkg::RESP_OKAY : gpcde_pkg::RESP_SLVERR;
        end
        // one write in flight: ready drops while held or answering
        awready_nxt = !aw_hold_nxt && !bvalid_nxt;
        wready_nxt = !w_hold_nxt && !bvalid_nxt;
    end

    // write channel registers
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            aw_idx_r <= '0;
            w_byte_r <= 8'h00;
            w_lane_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= gpcde_pkg::RESP_OKAY;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r <= w_hold_nxt;
            aw_idx_r <= aw_idx_nxt;
            w_byte_r <= w_byte_nxt;
            w_lane_r <= w_lane_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
        end
    end

    // read channel: data registers return latch or synchronised pin
    always_comb begin
        logic [IW-1:0] idx;
        idx = S_AXI_ARADDR[gpcde_pkg::IDX_LO +: IW];
        arready_nxt = arready_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (rvalid_r && S_AXI_RREADY) begin
            rvalid_nxt = 1'b0;
        end
        if (S_AXI_ARVALID && arready_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = gpcde_pkg::RESP_OKAY;
            // direction steers the read even on peripheral-owned pins
            if (idx == gpcde_pkg::IDX_C_DATA) begin
                rdata_nxt = 32'((c_dir_r & c_lat_r) | (~c_dir_r & c_s2_r));
            end else if (idx == gpcde_pkg::IDX_D_DATA) begin
                rdata_nxt = 32'((d_dir_r & d_lat_r) | (~d_dir_r & d_s2_r));
            end else if (idx == gpcde_pkg::IDX_E_DATA) begin
                rdata_nxt = 32'((e_dir_r & e_lat_r) | (~e_dir_r & e_s2_r));
            end else if (idx == gpcde_pkg::IDX_C_DIR) begin
                rdata_nxt = 32'(c_dir_r);
            end else if (idx == gpcde_pkg::IDX_D_DIR) begin
                rdata_nxt = 32'(d_dir_r);
            end else if (idx == gpcde_pkg::IDX_E_DIR) begin
                rdata_nxt = 32'(e_dir_r);
            end else if (idx == gpcde_pkg::IDX_C_PUE) begin
                rdata_nxt = 32'(c_pue_r);
            end else if (idx == gpcde_pkg::IDX_D_PUE) begin
                rdata_nxt = 32'(d_pue_r);
            end else if (idx == gpcde_pkg::IDX_MUX) begin
                rdata_nxt = 32'(mux_r);
            end else if (idx == gpcde_pkg::IDX_ELS) begin
                rdata_nxt = 32'(els_r);
            end else begin
                rdata_nxt = gpcde_pkg::DATA_ZERO;
                rresp_nxt = gpcde_pkg::RESP_SLVERR;
            end
        end
        // one read in flight at a time
        arready_nxt = !rvalid_nxt;
    end

    // read channel registers
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= gpcde_pkg::RESP_OKAY;
            rdata_r <= gpcde_pkg::DATA_ZERO;
        end else begin
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // outputs straight from flip-flops
    assign S_AXI_AWREADY = awready_r;
    assign S_AXI_WREADY = wready_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;
    assign S_AXI_ARREADY = arready_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RRESP = rresp_r;
    assign S_AXI_RDATA = rdata_r;
    assign PORT_C_DRV = c_drv_r;
    assign PORT_D_DRV = d_drv_r;
    assign PORT_E_DRV = e_drv_r;
    assign PORT_C_LEVEL = c_s2_r;
    assign PORT_D_LEVEL = d_s2_r;
    assign PORT_E_LEVEL = e_s2_r;
    assign PIN_MUX_CTRL = mux_r;
    assign TIMER_ELS = els_r;
endmodule // gpcde_top

// File: pkg/gpcde_pkg.sv
// shared constants and carrier types for the port c/d/e parallel i/o block
// assumes a 32-bit axi4-lite master and word-aligned register indices
package gpcde_pkg;
    // port widths
    localparam int C_W = 7;
    localparam int D_W = 8;
    localparam int E_W = 6;
    // bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_LO = 2; // byte address = index * 4
    localparam int IDX_W = 6;
    // register indices
    localparam logic [IDX_W-1:0] IDX_C_DATA = 6'h02;
    localparam logic [IDX_W-1:0] IDX_D_DATA = 6'h03;
    localparam logic [IDX_W-1:0] IDX_E_DATA = 6'h08;
    localparam logic [IDX_W-1:0] IDX_C_DIR = 6'h04;
    localparam logic [IDX_W-1:0] IDX_D_DIR = 6'h05;
    localparam logic [IDX_W-1:0] IDX_E_DIR = 6'h09;
    localparam logic [IDX_W-1:0] IDX_C_PUE = 6'h0C;
    localparam logic [IDX_W-1:0] IDX_D_PUE = 6'h0D;
    localparam logic [IDX_W-1:0] IDX_MUX = 6'h10;
    localparam logic [IDX_W-1:0] IDX_ELS = 6'h11;
    // pin sharing control register fields
    localparam int MUX_W = 4;
    localparam int MUX_CAN = 0;
    localparam int MUX_SPE = 1;
    localparam int MUX_MSTR = 2;
    localparam int MUX_SCI = 3;
    // timer edge/level select: two bits per channel, channels on port d 4..7
    localparam int ELS_W = 2;
    localparam int TIM_CH = 4;
    localparam int D_TIM_LO = 4;
    // shared pin masks
    localparam logic [C_W-1:0] C_CAN_MASK = 7'h03;
    localparam logic [D_W-1:0] D_SPI_MASK = 8'h0E;
    localparam logic [D_W-1:0] D_SS_MASK = 8'h01;
    localparam logic [E_W-1:0] E_SCI_MASK = 6'h03;
    // reset values
    localparam logic [C_W-1:0] C_ZERO = 7'h00;
    localparam logic [D_W-1:0] D_ZERO = 8'h00;
    localparam logic [E_W-1:0] E_ZERO = 6'h00;
    localparam logic [MUX_W-1:0] MUX_RST = 4'h0;
    localparam logic [TIM_CH*ELS_W-1:0] ELS_RST = 8'h00;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
    // pin drive groups: level, active-low output enable, pullup on (ports c and d only; port e has no pullup)
    typedef struct packed {
        logic [C_W-1:0] out;
        logic [C_W-1:0] oe_n;
        logic [C_W-1:0] pull;
    } gpcde_drv_c_t;
    typedef struct packed {
        logic [D_W-1:0] out;
        logic [D_W-1:0] oe_n;
        logic [D_W-1:0] pull;
    } gpcde_drv_d_t;
    typedef struct packed {
        logic [E_W-1:0] out;
        logic [E_W-1:0] oe_n;
    } gpcde_drv_e_t;
endpackage

// File: sim/gpcde_assertions.sv
// checker for the port c/d/e block: bus answers, pad drive, pullups, pin hand-over
// assumes it is bound into gpcde_top and sees only that module's ports
module gpcde_checker (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic S_AXI_AWVALID,
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WVALID,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic [31:0] S_AXI_RDATA,
    input wire gpcde_pkg::gpcde_drv_c_t PORT_C_DRV,
    input wire gpcde_pkg::gpcde_drv_d_t PORT_D_DRV,
    input wire gpcde_pkg::gpcde_drv_e_t PORT_E_DRV,
    input wire logic [6:0] PERIPH_C_OE,
    input wire logic [7:0] PERIPH_D_OE,
    input wire logic [5:0] PERIPH_E_OE,
    input wire logic [3:0] PIN_MUX_CTRL
);
    // one clock domain: sample on the rising edge, sleep through reset
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);
    // the reset check must watch reset itself, so it overrides the disable
    rst_release_a: assert property (disable iff (1'b0) RST |=> &PORT_C_DRV.oe_n
        && &PORT_D_DRV.oe_n && &PORT_E_DRV.oe_n) else $error("pads driven after reset");
    wr_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
        && S_AXI_WREADY |=> S_AXI_BVALID) else $error("write answer late");
    rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
    rd_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
        else $error("upper read bits set");
    // a pullup on a driven pad would fight the driver
    pull_c_a: assert property ((PORT_C_DRV.pull & ~PORT_C_DRV.oe_n) == 7'h00)
        else $error("port c pullup while driving");
    pull_d_a: assert property ((PORT_D_DRV.pull & ~PORT_D_DRV.oe_n) == 8'h00)
        else $error("port d pullup while driving");
    // owned pins follow the peripheral one cycle on, once the owner is settled
    can_own_a: assert property (PIN_MUX_CTRL[0] && $past(PIN_MUX_CTRL[0]) |->
        PORT_C_DRV.oe_n[1:0] == ~$past(PERIPH_C_OE[1:0])) else $error("can pins not handed over");
    spi_own_a: assert property (PIN_MUX_CTRL[1] && $past(PIN_MUX_CTRL[1]) |->
        PORT_D_DRV.oe_n[3:1] == ~$past(PERIPH_D_OE[3:1])) else $error("spi pins not handed over");
    ss_own_a: assert property (PIN_MUX_CTRL[2:1] == 2'h1 && $past(PIN_MUX_CTRL[2:1]) == 2'h1
        |-> PORT_D_DRV.oe_n[0] == ~$past(PERIPH_D_OE[0])) else $error("select pin not handed over");
    sci_own_a: assert property (PIN_MUX_CTRL[3] && $past(PIN_MUX_CTRL[3]) |->
        PORT_E_DRV.oe_n[1:0] == ~$past(PERIPH_E_OE[1:0])) else $error("serial pins not handed over");
endmodule // gpcde_checker

bind gpcde_top gpcde_checker u_gpcde_checker (.REF_CLK(REF_CLK), .RST(RST),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RDATA(S_AXI_RDATA),
    .PORT_C_DRV(PORT_C_DRV), .PORT_D_DRV(PORT_D_DRV), .PORT_E_DRV(PORT_E_DRV),
    .PERIPH_C_OE(PERIPH_C_OE), .PERIPH_D_OE(PERIPH_D_OE), .PERIPH_E_OE(PERIPH_E_OE),
    .PIN_MUX_CTRL(PIN_MUX_CTRL));

// File: sim/gpcde_pins.sv
// pad model: a driven pad shows the drive, else its pullup, else the outside level
// assumes oe_n low means the block drives the pad
module gpcde_pins (
    input wire gpcde_pkg::gpcde_drv_c_t drv_c,
    input wire gpcde_pkg::gpcde_drv_d_t drv_d,
    input wire gpcde_pkg::gpcde_drv_e_t drv_e,
    input wire logic [6:0] ext_c,
    input wire logic [7:0] ext_d,
    input wire logic [5:0] ext_e,
    output logic [6:0] pin_c,
    output logic [7:0] pin_d,
    output logic [5:0] pin_e
);
    timeunit 1ns;
    timeprecision 1ps;
    // the pullup only lifts a released pad
    assign pin_c = (~drv_c.oe_n & drv_c.out) | (drv_c.oe_n & (drv_c.pull | ext_c));
    assign pin_d = (~drv_d.oe_n & drv_d.out) | (drv_d.oe_n & (drv_d.pull | ext_d));
    // port e has no pullups
    assign pin_e = (~drv_e.oe_n & drv_e.out) | (drv_e.oe_n & ext_e);
endmodule // gpcde_pins

// File: sim/gpio_ports_c_d_e_tb.sv
// bench for the port c/d/e block: axi4-lite register traffic, pads via gpcde_pins
// assumes the checker is bound in from its own file
`define CK(g, e) begin n_compared++; if ((g) !== (e)) begin \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); n_fail++; end end
module gpio_ports_c_d_e_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, els;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0, mux;
    logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic awr, wrdy, bv, arr, rv;
    logic [1:0] bresp, rresp;
    logic [6:0] pco = 7'h00, pcoe = 7'h00, pin_c, lvl_c;
    logic [7:0] pdo = 8'h00, pdoe = 8'h00, pin_d, lvl_d;
    logic [5:0] peo = 6'h00, peoe = 6'h00, pin_e, lvl_e;
    gpcde_pkg::gpcde_drv_c_t drv_c;
    gpcde_pkg::gpcde_drv_d_t drv_d;
    gpcde_pkg::gpcde_drv_e_t drv_e;
    int n_fail = 0, n_compared = 0, cyc = 0;
    gpcde_top u_gpcde_top (.REF_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready),
        .PORT_C_IN(pin_c), .PORT_C_DRV(drv_c), .PORT_D_IN(pin_d), .PORT_D_DRV(drv_d),
        .PORT_E_IN(pin_e), .PORT_E_DRV(drv_e), .PERIPH_C_OUT(pco), .PERIPH_C_OE(pcoe),
        .PERIPH_D_OUT(pdo), .PERIPH_D_OE(pdoe), .PERIPH_E_OUT(peo), .PERIPH_E_OE(peoe),
        .PORT_C_LEVEL(lvl_c), .PORT_D_LEVEL(lvl_d), .PORT_E_LEVEL(lvl_e),
        .PIN_MUX_CTRL(mux), .TIMER_ELS(els));
    // outside levels on released pads, chosen so a wrong source shows
    gpcde_pins u_gpcde_pins (.drv_c(drv_c), .drv_d(drv_d), .drv_e(drv_e), .ext_c(7'h2A),
        .ext_d(8'hC3), .ext_e(6'h15), .pin_c(pin_c), .pin_d(pin_d), .pin_e(pin_e));
    initial begin
        forever #4 clk = ~clk;
    end
    // one write; address and data released each as it is taken
    task automatic wr(input logic [5:0] i, input logic [7:0] d, input logic [3:0] s = 4'hF,
        input logic [1:0] e = 2'h0);
        @(posedge clk);
        awaddr <= {i, 2'h0};
        wdata <= {24'h000000, d};
        wstrb <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        fork
            begin
                do @(posedge clk); while (!awr);
                awv <= 1'b0;
            end
            begin
                do @(posedge clk); while (!wrdy);
                wv <= 1'b0;
            end
        join
        while (!bv) @(posedge clk);
        bready <= 1'b0;
        `CK(bresp, e)
    endtask
    // one read compared with its expected data and response
    task automatic rc(input logic [5:0] i, input logic [31:0] x, input logic [1:0] e = 2'h0);
        @(posedge clk);
        araddr <= {i, 2'h0};
        arv <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        do @(posedge clk); while (!rv);
        rready <= 1'b0;
        `CK(rdata, x)
        `CK(rresp, e)
    endtask
    // let pad changes land and pass the two sync flops
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic give_verdict();
        $display("compared %0d, mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        idle(2);
        `CK({drv_c.oe_n, lvl_c, lvl_d, lvl_e}, {7'h7F, 7'h2A, 8'hC3, 6'h15})
        rc(gpcde_pkg::IDX_D_DIR, 32'h0);
        rc(gpcde_pkg::IDX_E_DIR, 32'h0);
        $display("test reset done");
        // latch first, then direction, so no glitch on the pads
        wr(gpcde_pkg::IDX_C_DATA, 8'hD5);
        rc(gpcde_pkg::IDX_C_DATA, 32'h2A);
        wr(gpcde_pkg::IDX_C_DIR, 8'hFF);
        rc(gpcde_pkg::IDX_C_DIR, 32'h7F);
        rc(gpcde_pkg::IDX_C_DATA, 32'h55);
        `CK(drv_c, {7'h55, 7'h00, 7'h00})
        wr(gpcde_pkg::IDX_C_DIR, 8'h0F);
        wr(gpcde_pkg::IDX_C_PUE, 8'hFF);
        idle(3);
        `CK(drv_c.pull, 7'h70)
        rc(gpcde_pkg::IDX_C_DATA, 32'h75);
        wr(gpcde_pkg::IDX_C_PUE, 8'h00);
        idle(3);
        rc(gpcde_pkg::IDX_C_DATA, 32'h25);
        $display("test port c done");
        wr(gpcde_pkg::IDX_D_DATA, 8'h3C);
        wr(gpcde_pkg::IDX_D_DIR, 8'hF0);
        wr(gpcde_pkg::IDX_D_PUE, 8'hFF);
        idle(3);
        `CK(drv_d, {8'h30, 8'h0F, 8'h0F})
        rc(gpcde_pkg::IDX_D_DATA, 32'h3F);
        wr(gpcde_pkg::IDX_E_DATA, 8'hEA);
        wr(gpcde_pkg::IDX_E_DIR, 8'h0F);
        idle(3);
        `CK(drv_e, {6'h0A, 6'h30})
        rc(gpcde_pkg::IDX_E_DATA, 32'h1A);
        $display("test ports d e done");
        // a second reset clears directions but keeps the latches
        rst <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        idle(2);
        `CK(drv_c.oe_n, 7'h7F)
        wr(gpcde_pkg::IDX_C_DIR, 8'hFF);
        wr(gpcde_pkg::IDX_E_DIR, 8'hFF);
        rc(gpcde_pkg::IDX_C_DATA, 32'h55);
        rc(gpcde_pkg::IDX_E_DATA, 32'h2A);
        $display("test latch hold done");
        pco <= 7'h7F;
        pcoe <= 7'h7F;
        wr(gpcde_pkg::IDX_C_DIR, 8'h00);
        wr(gpcde_pkg::IDX_MUX, 8'h01);
        idle(3);
        `CK({drv_c.out, drv_c.oe_n}, {7'h03, 7'h7C})
        pdo <= 8'hFF;
        wr(gpcde_pkg::IDX_D_DIR, 8'h0F);
        wr(gpcde_pkg::IDX_MUX, 8'h02);
        idle(3);
        `CK({drv_d.out, drv_d.oe_n}, {8'h00, 8'hFF})
        rc(gpcde_pkg::IDX_D_DATA, 32'hCC);
        wr(gpcde_pkg::IDX_MUX, 8'h06);
        idle(3);
        `CK(drv_d.oe_n, 8'hFE)
        pdo <= 8'h80;
        pdoe <= 8'h80;
        wr(gpcde_pkg::IDX_ELS, 8'h40);
        idle(3);
        `CK({drv_d.out, drv_d.oe_n, mux, els}, {8'h80, 8'h7E, 4'h6, 8'h40})
        peoe <= 6'h01;
        wr(gpcde_pkg::IDX_MUX, 8'h08);
        idle(3);
        `CK(drv_e, {6'h28, 6'h02})
        rc(gpcde_pkg::IDX_E_DATA, 32'h2A);
        $display("test pin sharing done");
        wr(6'h3F, 8'hFF, 4'hF, gpcde_pkg::RESP_SLVERR);
        rc(6'h3F, 32'h0, gpcde_pkg::RESP_SLVERR);
        wr(gpcde_pkg::IDX_C_PUE, 8'h7F, 4'h0);
        rc(gpcde_pkg::IDX_C_PUE, 32'h0);
        wr(gpcde_pkg::IDX_C_PUE, 8'hFF);
        rc(gpcde_pkg::IDX_C_PUE, 32'h7F);
        $display("test refusals done");
        give_verdict();
    end
endmodule // gpio_ports_c_d_e_tb
